// File: logic/cdce_pkg.sv
package cdce_pkg;
    // Configuration sequencer states, one-hot.
    typedef enum logic [5:0] {
        CDCE_IDLE = 6'h01,
        CDCE_WAIT = 6'h02,
        CDCE_LOAD = 6'h04,
        CDCE_INIT = 6'h08,
        CDCE_USER = 6'h10,
        CDCE_ERR = 6'h20
    } cdce_state_t;
    // Active configuration scheme, selecting the flash-select role.
    typedef enum logic [1:0] {
        CDCE_PASSIVE = 2'h0,
        CDCE_ACT_SERIAL = 2'h1,
        CDCE_ACT_PARALLEL = 2'h2
    } cdce_scheme_t;
endpackage

// File: logic/cdce_regs.svh
`ifndef CDCE_REGS_SVH
`define CDCE_REGS_SVH
// Timing counts in reference clock cycles.
`define CDCE_INIT_CYCLES 16'h0010
`define CDCE_COUNT_ONE 16'h0001
`define CDCE_COUNT_ZERO 16'h0000
`endif

// File: logic/cdce_top.sv
`include "cdce_regs.svh"
// Notes on behaviour
// - Hold status line low until data received.
// - Release status line when initialization starts.
// - Initialize after status seen high, then user.
// - Ignore external status low in user mode.
// - Configure only while chip enable low.
// - Drive chain enable low when configured.
// - Chain start waits on previous chain enable.
// - Option off frees chain pin as user I/O.
// - Serial scheme drives memory select low.
// - Parallel scheme uses select as flash enable.
// - One select pin, role set by scheme.
// - Restart high after low begins new configuration.
module cdce_top #(
    parameter int INIT_WIDTH = 16
) (
    input wire logic REF_CLK_I, // Reference clock, 250 MHz.
    input wire logic ARST_N_I, // Asynchronous reset, active low.
    input wire logic CONFIG_RESTART_N_I, // Configuration restart pin, active low.
    input wire logic CHIP_ENABLE_N_I, // Chip enable pin, active low.
    input wire logic STATUS_I, // Level on the configuration-complete line.
    input wire cdce_pkg::cdce_scheme_t SCHEME_I, // Configuration scheme, strapped.
    input wire logic DATA_DONE_I, // Loader has received all data, same clock.
    input wire logic DATA_ERR_I, // Loader saw a data error, same clock.
    input wire logic CHAIN_DEDICATED_I, // Chain pin stays dedicated after configuration.
    input wire logic USER_CHAIN_O_I, // Dual-purpose setting for the chain pin level.
    output logic STATUS_O, // Status line output level, always low.
    output logic STATUS_OE_O, // Status line drive enable, high while driving low.
    output logic CHAIN_ENABLE_OUT_N_O, // Chain enable to the next device, active low.
    output logic FLASH_SELECT_N_O, // Flash select, active low.
    output logic LOADING_O, // High while configuration data is accepted.
    output logic USER_MODE_O // High in user mode.
);
    import cdce_pkg::*;

    // Refuse a counter too narrow to reach the initialization count.
    if (INIT_WIDTH < 5) begin
        $error("INIT_WIDTH too small for the initialization count");
    end

    // Two-stage synchronisers for the pins.
    logic [1:0] rst_s_q, ce_s_q, st_s_q;
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_s_q <= 2'h0;
            ce_s_q <= 2'h3;
            st_s_q <= 2'h0;
        end else begin
            rst_s_q <= {rst_s_q[0], CONFIG_RESTART_N_I};
            ce_s_q <= {ce_s_q[0], CHIP_ENABLE_N_I};
            st_s_q <= {st_s_q[0], STATUS_I};
        end
    end

    // The scheme straps are pins too, so they pass two flip-flops before the decode.
    cdce_scheme_t sch_s0_q, sch_s1_q;
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sch_s0_q <= CDCE_PASSIVE;
            sch_s1_q <= CDCE_PASSIVE;
        end else begin
            sch_s0_q <= SCHEME_I;
            sch_s1_q <= sch_s0_q;
        end
    end

    wire restart_n = rst_s_q[1];
    wire ce_n = ce_s_q[1];
    wire status_hi = st_s_q[1];

    cdce_state_t state_q, state_d;
    logic [INIT_WIDTH-1:0] cnt_q, cnt_d;
    logic restart_prev_q;

    // A rising restart edge begins a fresh configuration.
    wire restart_rise = restart_n & ~restart_prev_q;
    wire init_done = (cnt_q == INIT_WIDTH'(`CDCE_INIT_CYCLES));

    // Next-state decode.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            CDCE_IDLE: begin
                if (restart_n) begin
                    state_d = CDCE_WAIT;
                end
            end
            CDCE_WAIT: begin
                if (!ce_n) begin
                    state_d = CDCE_LOAD;
                end
            end
            CDCE_LOAD: begin
                if (ce_n) begin
                    state_d = CDCE_WAIT;
                end else if (DATA_ERR_I) begin
                    state_d = CDCE_ERR;
                end else if (DATA_DONE_I) begin
                    state_d = CDCE_INIT;
                    cnt_d = INIT_WIDTH'(`CDCE_COUNT_ZERO);
                end
            end
            CDCE_INIT: begin
                if (status_hi && !init_done) begin
                    cnt_d = cnt_q + INIT_WIDTH'(`CDCE_COUNT_ONE);
                end else if (status_hi) begin
                    state_d = CDCE_USER;
                end
            end
            CDCE_USER: state_d = CDCE_USER;
            CDCE_ERR: state_d = CDCE_ERR;
            default: state_d = CDCE_IDLE;
        endcase
        if (!restart_n) begin
            state_d = CDCE_IDLE;
        end
    end

    // Pin decode from the next state.
    wire drive_low = (state_d != CDCE_INIT) && (state_d != CDCE_USER);
    wire chain_n = (state_d != CDCE_USER) ? 1'b1 :
                   (CHAIN_DEDICATED_I ? 1'b0 : USER_CHAIN_O_I);
    wire sel_role = (sch_s1_q == CDCE_ACT_SERIAL) || (sch_s1_q == CDCE_ACT_PARALLEL);
    wire flash_n = ~(sel_role && (state_d == CDCE_LOAD));

    // State and output registers.
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_q <= CDCE_IDLE;
            cnt_q <= '0;
            restart_prev_q <= 1'b0;
            STATUS_O <= 1'b0;
            STATUS_OE_O <= 1'b1;
            CHAIN_ENABLE_OUT_N_O <= 1'b1;
            FLASH_SELECT_N_O <= 1'b1;
            LOADING_O <= 1'b0;
            USER_MODE_O <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            restart_prev_q <= restart_n;
            STATUS_O <= 1'b0;
            STATUS_OE_O <= drive_low;
            CHAIN_ENABLE_OUT_N_O <= chain_n;
            FLASH_SELECT_N_O <= flash_n;
            LOADING_O <= (state_d == CDCE_LOAD);
            USER_MODE_O <= (state_d == CDCE_USER);
        end
    end

    // Status line is driven low while configuration data loads.
    property p_status_low;
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (state_q == CDCE_LOAD) |-> STATUS_OE_O;
    endproperty
    a_status_low: assert property (p_status_low) else $error("status not driven");

    property p_release;
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (state_q == CDCE_LOAD && !ce_n && !DATA_ERR_I && DATA_DONE_I && restart_n)
            |=> !STATUS_OE_O;
    endproperty
    a_release: assert property (p_release) else $error("status not released");

    property p_user_stays;
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (USER_MODE_O && restart_n) |=> USER_MODE_O;
    endproperty
    a_user_stays: assert property (p_user_stays) else $error("user mode lost");

    property p_load_ce;
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        LOADING_O |-> $past(ce_n) == 1'b0;
    endproperty
    a_load_ce: assert property (p_load_ce) else $error("load without enable");

    property p_chain;
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (USER_MODE_O && $past(CHAIN_DEDICATED_I)) |-> !CHAIN_ENABLE_OUT_N_O;
    endproperty
    a_chain: assert property (p_chain) else $error("chain not low");

    property p_chain_hold;
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        !USER_MODE_O |-> CHAIN_ENABLE_OUT_N_O;
    endproperty
    a_chain_hold: assert property (p_chain_hold) else $error("chain early");

    property p_select;
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        !FLASH_SELECT_N_O |-> (LOADING_O && $past(sch_s1_q) != CDCE_PASSIVE);
    endproperty
    a_select: assert property (p_select) else $error("bad flash select");

    property p_restart;
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        !restart_n |=> (!USER_MODE_O && STATUS_OE_O && CHAIN_ENABLE_OUT_N_O);
    endproperty
    a_restart: assert property (p_restart) else $error("restart ignored");

    // A rising restart begins afresh with the status line held and the chain released.
    property p_fresh;
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        restart_rise |=> (STATUS_OE_O && CHAIN_ENABLE_OUT_N_O && !LOADING_O && !USER_MODE_O);
    endproperty
    a_fresh: assert property (p_fresh) else $error("restart did not begin afresh");

    // A low drive from outside on the status line leaves user mode in place.
    property p_st_ignore;
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (USER_MODE_O && !status_hi && restart_n) |=> (USER_MODE_O && !STATUS_OE_O);
    endproperty
    a_st_ignore: assert property (p_st_ignore) else $error("user mode upset");

    // User mode is entered only after the full count with the status line high.
    property p_init_done;
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        $rose(USER_MODE_O) |-> ($past(status_hi) && $past(init_done));
    endproperty
    a_init_done: assert property (p_init_done) else $error("user mode too early");

    // A data error keeps the status line held and the chain released until restart.
    property p_err_hold;
        @(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (state_q == CDCE_ERR && restart_n) |=> (STATUS_OE_O && CHAIN_ENABLE_OUT_N_O);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error state left");
endmodule

// File: verif/cdce_host_model.sv
// Far side: pulled-up status wire, neighbour drive and a data loader.
module cdce_host_model (
    input wire logic clk_i, // Reference clock.
    input wire logic loading_i, // Device accepts data.
    input wire logic oe_i, // Device pulls the status wire low.
    input wire logic ext_low_i, // A neighbour pulls the status wire low.
    input wire logic err_mode_i, // Send a corrupt image.
    output logic status_o, // Status wire level.
    output logic done_o = 1'b0, // All data received.
    output logic err_o = 1'b0 // Data error seen.
);
    logic [2:0] cnt_q = 3'h0;
    // Open-drain wire with pull-up, low while any party drives it.
    assign status_o = !(oe_i || ext_low_i);
    // The image lasts eight cycles, then done or error is reported for one cycle.
    always @(negedge clk_i) begin
        cnt_q <= loading_i ? cnt_q + 3'h1 : 3'h0;
        done_o <= loading_i && (cnt_q == 3'h7) && !err_mode_i;
        err_o <= loading_i && (cnt_q == 3'h7) && err_mode_i;
    end
endmodule

// File: verif/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cdce_pkg::*;
    typedef struct {cdce_scheme_t sch; logic fl;} cdce_tb_row_t;
    logic clk = 1'b0, rst_n = 1'b0, restart_n = 1'b0, ext_low = 1'b0, err_mode = 1'b0;
    logic ce_n = 1'b0;
    logic ded = 1'b1, uchain = 1'b1, st, done, err, st_o, oe, chain_n, flash_n, loading, user;
    cdce_scheme_t scheme = CDCE_PASSIVE;
    int bad_count = 0, n_tests = 0;
    cdce_tb_row_t rows [3] = '{'{CDCE_PASSIVE, 1'b1}, '{CDCE_ACT_SERIAL, 1'b0},
        '{CDCE_ACT_PARALLEL, 1'b0}};
    // The clock toggles every 2 ns.
    initial forever #2 clk = ~clk;
    cdce_top cdce_top_i (.REF_CLK_I(clk), .ARST_N_I(rst_n), .CONFIG_RESTART_N_I(restart_n),
        .CHIP_ENABLE_N_I(ce_n), .STATUS_I(st), .SCHEME_I(scheme), .DATA_DONE_I(done),
        .DATA_ERR_I(err), .CHAIN_DEDICATED_I(ded), .USER_CHAIN_O_I(uchain), .STATUS_O(st_o),
        .STATUS_OE_O(oe), .CHAIN_ENABLE_OUT_N_O(chain_n), .FLASH_SELECT_N_O(flash_n),
        .LOADING_O(loading), .USER_MODE_O(user));
    cdce_host_model cdce_host_model_i (.clk_i(clk), .loading_i(loading), .oe_i(oe),
        .ext_low_i(ext_low), .err_mode_i(err_mode), .status_o(st), .done_o(done), .err_o(err));
    // Compares status, enable, chain, flash, loading and user mode together.
    task chk(input logic [5:0] exp);
        n_tests++;
        if ({st_o, oe, chain_n, flash_n, loading, user} !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time,
                {st_o, oe, chain_n, flash_n, loading, user}, exp);
        end
    endtask
    // Waits a bounded time for loading (0) or user mode (1).
    task wait_st(input logic sel);
        int i;
        i = 0;
        while ((sel ? user : loading) !== 1'b1 && i < 100) begin
            @(negedge clk);
            i++;
        end
        if ((sel ? user : loading) !== 1'b1) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, sel ? user : loading, 1'b1);
        end
    endtask
    // Prints the verdict and ends the run.
    task test_done;
        if (bad_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Sequence per scheme, then the awkward cases.
    initial begin
        repeat (3) @(negedge clk);
        chk(6'h1c);
        rst_n = 1'b1;
        foreach (rows[k]) begin
            restart_n = 1'b0;
            scheme = rows[k].sch;
            repeat (4) @(negedge clk);
            restart_n = 1'b1;
            wait_st(1'b0);
            chk({3'h3, rows[k].fl, 2'h2});
            wait_st(1'b1);
            chk(6'h05);
        end
        ext_low = 1'b1;
        repeat (8) @(negedge clk);
        chk(6'h05);
        ext_low = 1'b0;
        ded = 1'b0;
        repeat (4) @(negedge clk);
        chk(6'h0d);
        uchain = 1'b0;
        repeat (4) @(negedge clk);
        chk(6'h05);
        ded = 1'b1;
        restart_n = 1'b0;
        ce_n = 1'b1;
        repeat (4) @(negedge clk);
        restart_n = 1'b1;
        repeat (20) @(negedge clk);
        chk(6'h1c);
        err_mode = 1'b1;
        ce_n = 1'b0;
        wait_st(1'b0);
        repeat (30) @(negedge clk);
        chk(6'h1c);
        test_done;
    end
    // Cuts a hang short long after the sequence should have finished.
    initial begin
        #20us;
        bad_count++;
        test_done;
    end
endmodule
